// ---- host_mode_regs.sv ----
// operating-mode control and command status registers of the host side
// assumes command codes arrive synchronously with a one-cycle strobe
`timescale 1ns/1ns
module host_mode_regs
   import host_ctl_pkg::*;
#(
   parameter logic [15:0] SOF_DELAY_CYCLES = SOF_DELAY_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] cmd_wdata,
   input wire logic resume_seen_flag,
   input wire logic port_resume_detect,
   input wire logic eof_pulse,
   input wire logic periodic_done,
   output logic [31:0] rd_data,
   output logic rd_valid,
   output logic wakeup_signal,
   output logic sof_run,
   output logic overrun_flag_set,
   output logic hub_reset,
   output logic [1:0] functional_state
);
   typedef struct packed {
      logic wakeup_enable;
      logic wakeup_connected;
      logic [1:0] fs;
      logic sw_reset;
      logic [1:0] soc;
      logic overrun_set;
      logic wake;
      logic hub_reset;
      logic [31:0] rd_data;
      logic rd_valid;
   } regs_state_t;

   localparam regs_state_t STATE_RST = '{
      wakeup_enable: 1'b0, wakeup_connected: 1'b0, fs: FS_RESET,
      sw_reset: 1'b0, soc: 2'h0, overrun_set: 1'b0, wake: 1'b0,
      hub_reset: 1'b1, rd_data: 32'h0000_0000, rd_valid: 1'b0};

   // register images; reserved positions stay zero
   function automatic logic [31:0] reg_image(input logic [7:0] code,
                                             input regs_state_t st);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (code == CODE_CTRL_RD) begin
         v[CTRL_WAKE_EN_BIT] = st.wakeup_enable;
         v[CTRL_WAKE_CONN_BIT] = st.wakeup_connected;
         v[CTRL_FS_LSB +: 2] = st.fs;
      end else if (code == CODE_CMD_RD) begin
         v[CMD_SW_RESET_BIT] = st.sw_reset;
         v[CMD_SOC_LSB +: 2] = st.soc;
      end
      return v;
   endfunction

   logic rst_meta;
   logic rst_n;
   regs_state_t s_reg;
   regs_state_t s_next;
   logic wr_ctrl;
   logic wr_cmd;
   logic rd_any;
   logic overrun;
   sof_timer_if tif ();

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign wr_ctrl = cmd_strobe && cmd_code == CODE_CTRL_WR;
   assign wr_cmd = cmd_strobe && cmd_code == CODE_CMD_WR;
   assign rd_any = cmd_strobe && !cmd_code[7];
   assign overrun = eof_pulse && !periodic_done;

   always_comb begin
      s_next = s_reg;
      s_next.rd_valid = 1'b0;
      s_next.overrun_set = 1'b0;
      s_next.hub_reset = 1'b0;
      // wake-up only, no interrupt path here
      s_next.wake = s_reg.wakeup_enable & resume_seen_flag;
      if (overrun) begin
         s_next.soc = s_reg.soc + SOC_ONE;
         s_next.overrun_set = 1'b1;
      end
      if (s_reg.sw_reset) begin
         // soft reset: wake bits kept
         s_next.fs = FS_RESET;
         s_next.sw_reset = 1'b0;
      end else begin
         if (s_reg.fs == FS_SUSPEND && port_resume_detect) begin
            s_next.fs = FS_RESUME;
         end
         if (wr_ctrl) begin
            // only path that alters wake enable
            s_next.wakeup_enable = cmd_wdata[CTRL_WAKE_EN_BIT];
            s_next.wakeup_connected = cmd_wdata[CTRL_WAKE_CONN_BIT];
            s_next.fs = cmd_wdata[CTRL_FS_LSB +: 2];
         end
      end
      if (wr_cmd && cmd_wdata[CMD_SW_RESET_BIT]) begin
         s_next.sw_reset = 1'b1;
      end
      if (rd_any) begin
         s_next.rd_valid = 1'b1;
         s_next.rd_data = reg_image(cmd_code, s_reg);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= STATE_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign tif.ce = ce;
   assign tif.start = ce && s_next.fs == FS_OPER
                      && s_reg.fs != FS_OPER;
   assign tif.stop = ce && s_next.fs != FS_OPER;

   sof_delay_timer #(
      .DELAY(SOF_DELAY_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .t(tif.tmr)
   );

   assign rd_data = s_reg.rd_data;
   assign rd_valid = s_reg.rd_valid;
   assign wakeup_signal = s_reg.wake;
   assign sof_run = tif.sof_on;
   assign overrun_flag_set = s_reg.overrun_set;
   assign hub_reset = s_reg.hub_reset;
   assign functional_state = s_reg.fs;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   wake_follow_a: assert property (
      ce && s_reg.wakeup_enable && resume_seen_flag |=> wakeup_signal)
      else $error("wake-up not signalled");
   wake_en_hold_a: assert property (
      ce && !wr_ctrl |=> $stable(s_reg.wakeup_enable))
      else $error("wake enable changed without a write");
   conn_keep_a: assert property (
      ce && s_reg.sw_reset |=> $stable(s_reg.wakeup_connected))
      else $error("soft reset altered connected bit");
   fs_hold_a: assert property (
      ce && !wr_ctrl && !s_reg.sw_reset && s_reg.fs != FS_SUSPEND
      |=> $stable(s_reg.fs))
      else $error("state changed outside suspend");
   resume_move_a: assert property (
      ce && !wr_ctrl && !s_reg.sw_reset && s_reg.fs == FS_SUSPEND
      && port_resume_detect |=> functional_state == FS_RESUME)
      else $error("suspend did not move to resume");
   soft_reset_a: assert property (
      ce && s_reg.sw_reset && !wr_cmd |=> functional_state == FS_RESET
      && !s_reg.sw_reset && !sof_run)
      else $error("soft reset did not reach reset state");
   set_only_a: assert property (
      ce && wr_cmd && !s_reg.sw_reset |=> s_reg.sw_reset
      == $past(cmd_wdata[CMD_SW_RESET_BIT]))
      else $error("command write did not set bit");
   soc_bump_a: assert property (
      ce && overrun |=> overrun_flag_set
      && s_reg.soc == $past(s_reg.soc) + SOC_ONE)
      else $error("overrun not counted");
   rsvd_zero_a: assert property (
      rd_valid |-> rd_data[31:18] == 14'h0000 && rd_data[15:11] == 5'h00
      && rd_data[8] == 1'b0 && rd_data[5:1] == 5'h00)
      else $error("reserved bits read non-zero");
   hub_once_a: assert property (
      // release edge skipped, state still held there
      ce && rst_n && hub_reset |=> !hub_reset)
      else $error("hub reset held too long");

   hub_quiet_a: assert property (
      ce && !hub_reset |=> !hub_reset)
      else $error("hub reset raised outside hard reset");
   wake_drop_a: assert property (
      ce && !s_reg.wakeup_enable |=> !wakeup_signal)
      else $error("wake-up signalled while disabled");
   conn_write_a: assert property (
      ce && !wr_ctrl |=> $stable(s_reg.wakeup_connected))
      else $error("connected bit changed without a write");
   sof_off_a: assert property (
      functional_state != FS_OPER |-> !sof_run)
      else $error("frame start running outside operational");
   soc_still_a: assert property (
      ce && !overrun |=> $stable(s_reg.soc) && !overrun_flag_set)
      else $error("overrun count moved without overrun");
   read_answer_a: assert property (
      ce && rd_any |=> rd_valid)
      else $error("read not answered");
   read_once_a: assert property (
      ce && !rd_any |=> !rd_valid)
      else $error("read answer held too long");
   read_clean_a: assert property (
      ce && rd_any && !overrun |=> $stable(s_reg.soc)
      && $stable(s_reg.wakeup_enable) && $stable(s_reg.wakeup_connected))
      else $error("read disturbed register state");
   rd_unknown_a: assert property (
      ce && rd_any && cmd_code != CODE_CTRL_RD && cmd_code != CODE_CMD_RD
      |=> rd_data == 32'h0000_0000)
      else $error("unknown read code returned data");

   soft_reset_c: cover property (ce && s_reg.sw_reset);
   read_c: cover property (ce && rd_any ##1 rd_valid);
   resume_c: cover property (s_reg.fs == FS_SUSPEND ##1
                             functional_state == FS_RESUME);
   soc_wrap_c: cover property (s_reg.soc == 2'h3 ##1 s_reg.soc == 2'h0);
endmodule

// ---- host_ctl_pkg.sv ----
// constants for the host operating-mode and command register block
// assumes a 20 MHz controller clock and the command-code register port
// Notes on behaviour
// - wake enable plus resume flag signals wake-up
// - wake enable never gates interrupt generation
// - only host writes change wake enable
// - state codes: reset, resume, operational, suspend
// - frame starts begin 1 ms after operational
// - controller alters state only while suspended
// - suspended controller moves to resume on detect
// - any reset puts state field at reset
// - hard reset also resets hub and ports
// - command writes set ones, ignore zeros
// - command register reads plainly, no side effects
// - overrun when periodic list misses frame end
// - overrun bumps counter and raises overrun flag
// - overrun counter starts zero, wraps at max
// - counter bumps even with flag already set
package host_ctl_pkg;
   // command codes: read code, write code = read code with bit 7
   localparam logic [7:0] CODE_CTRL_RD = 8'h01;
   localparam logic [7:0] CODE_CTRL_WR = 8'h81;
   localparam logic [7:0] CODE_CMD_RD = 8'h02;
   localparam logic [7:0] CODE_CMD_WR = 8'h82;
   // operating control fields
   localparam int CTRL_WAKE_EN_BIT = 10;
   localparam int CTRL_WAKE_CONN_BIT = 9;
   localparam int CTRL_FS_LSB = 6;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // command status fields
   localparam int CMD_SW_RESET_BIT = 0;
   localparam int CMD_SOC_LSB = 16;
   localparam logic [31:0] CMD_RST = 32'h0000_0000;
   // functional state encodings
   localparam logic [1:0] FS_RESET = 2'h0;
   localparam logic [1:0] FS_RESUME = 2'h1;
   localparam logic [1:0] FS_OPER = 2'h2;
   localparam logic [1:0] FS_SUSPEND = 2'h3;
   // frame-start delay
   localparam int SOF_DELAY_NS = 1000000;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [15:0] SOF_DELAY_CYC =
      16'((SOF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [1:0] SOC_ONE = 2'h1;
   typedef enum logic [2:0] {
      T_IDLE = 3'h1,
      T_COUNT = 3'h2,
      T_RUN = 3'h4
   } tstate_t;
endpackage

// ---- sof_timer_if.sv ----
// carrier between the register block and its frame-start delay timer
// assumes both ends run on the controller clock
`timescale 1ns/1ns
interface sof_timer_if;
   logic start;
   logic stop;
   logic ce;
   logic sof_on;
   modport ctl (output start, output stop, output ce, input sof_on);
   modport tmr (input start, input stop, input ce, output sof_on);
endinterface

// ---- sof_delay_timer.sv ----
// frame-start delay timer: raises sof_on a set count after start
// assumes start and stop come from the register block, same clock
`timescale 1ns/1ns
module sof_delay_timer
   import host_ctl_pkg::*;
#(
   parameter logic [15:0] DELAY = SOF_DELAY_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   sof_timer_if.tmr t
);
   typedef struct packed {
      tstate_t st;
      logic [15:0] cnt;
   } timer_state_t;

   timer_state_t s_reg;
   timer_state_t s_next;

   assign t.sof_on = s_reg.st[2];

   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         T_IDLE: ;
         T_COUNT: begin
            if (s_reg.cnt == 16'h0000) begin
               s_next.st = T_RUN;
            end else begin
               s_next.cnt = s_reg.cnt - CNT_ONE;
            end
         end
         T_RUN: ;
         default: s_next.st = T_IDLE;
      endcase
      if (t.stop) begin
         s_next.st = T_IDLE;
      end
      if (t.start) begin
         s_next.st = T_COUNT;
         s_next.cnt = DELAY - CNT_ONE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: T_IDLE, cnt: 16'h0000};
      end else if (t.ce) begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sof_on_time_a: assert property (
      t.ce && s_reg.st == T_COUNT && s_reg.cnt == 16'h0000 && !t.stop
      && !t.start |=> t.sof_on)
      else $error("frame start not raised at end of delay");
   start_quiet_a: assert property (
      t.start && t.ce |=> !t.sof_on ##0 s_reg.cnt == DELAY - CNT_ONE)
      else $error("frame start raised too early");
   sof_start_c: cover property ($rose(t.sof_on));
endmodule

// ---- host_drv_model.sv ----
// host driver model: issues read and write command codes
// assumes a one-cycle strobe taken on the rising edge of mclk
`timescale 1ns/1ns
module host_drv_model
   import host_ctl_pkg::*;
(
   input wire logic mclk,
   output logic cmd_strobe,
   output logic [7:0] cmd_code,
   output logic [31:0] cmd_wdata,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid
);
   initial begin
      cmd_strobe = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 32'h0000_0000;
   end
   task automatic wr(input logic [7:0] code, input logic [31:0] d);
      @(posedge mclk);
      #1;
      cmd_strobe = 1'b1;
      cmd_code = code;
      cmd_wdata = d;
      @(posedge mclk);
      #1;
      cmd_strobe = 1'b0;
      // stale data is not left on the bus
      cmd_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] code, output logic [31:0] d);
      wr(code, 32'h0000_0000);
      d = 32'hxxxx_xxxx;
      for (int n = 0; n < 3; n++) begin
         if (rd_valid === 1'b1) begin
            d = rd_data;
            break;
         end
         @(posedge mclk);
         #1;
      end
   endtask
   // firmware marks wake-up as wired during self test
   task automatic post();
      wr(CODE_CTRL_WR, 32'h0000_0200);
   endtask
endmodule

// ---- test_usb_host_mode_and_command_regs.sv ----
// testbench for the host operating-mode and command register block
// assumes the host driver model sits on the command-code port
`timescale 1ns/1ns
module test_usb_host_mode_and_command_regs
   import host_ctl_pkg::*;
();
   localparam logic [15:0] SOFD = 16'h0014;
   logic mclk = 1'b0;
   logic nrst, ce, resume_seen_flag, port_resume_detect, eof_pulse;
   logic periodic_done, cmd_strobe, rd_valid, wakeup_signal, sof_run;
   logic overrun_flag_set, hub_reset;
   logic [7:0] cmd_code;
   logic [31:0] cmd_wdata, rd_data, v;
   logic [1:0] functional_state;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n;
   always #25 mclk = ~mclk;
   host_mode_regs #(.SOF_DELAY_CYCLES(SOFD)) host_mode_regs_i (
      .mclk(mclk), .nrst(nrst), .ce(ce), .cmd_strobe(cmd_strobe),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .resume_seen_flag(resume_seen_flag),
      .port_resume_detect(port_resume_detect), .eof_pulse(eof_pulse),
      .periodic_done(periodic_done), .rd_data(rd_data),
      .rd_valid(rd_valid), .wakeup_signal(wakeup_signal),
      .sof_run(sof_run), .overrun_flag_set(overrun_flag_set),
      .hub_reset(hub_reset), .functional_state(functional_state));
   host_drv_model host_drv_model_i (.mclk(mclk), .cmd_strobe(cmd_strobe),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
      .rd_valid(rd_valid));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] code, input logic [31:0] exp);
      host_drv_model_i.rd(code, v);
      chk(v, exp);
   endtask
   task automatic wr(input logic [7:0] code, input logic [31:0] d);
      host_drv_model_i.wr(code, d);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic hw_reset();
      nrst = 1'b0;
      cyc(12);
      chk({31'h0, hub_reset}, 32'h1);
      chk({30'h0, functional_state}, 32'h0);
      nrst = 1'b1;
      cyc(4);
      chk({31'h0, hub_reset}, 32'h0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(50 * 3000);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {nrst, resume_seen_flag, port_resume_detect, eof_pulse} = 4'h0;
      ce = 1'b1;
      periodic_done = 1'b1;
      hw_reset();
      rchk(CODE_CTRL_RD, CTRL_RST);
      rchk(CODE_CMD_RD, CMD_RST);
      host_drv_model_i.post();
      wr(CODE_CTRL_WR, 32'hffff_fb3f);
      rchk(CODE_CTRL_RD, 32'h0000_0200);
      $display("reset values done");
      for (int s = 0; s < 4; s++) begin
         wr(CODE_CTRL_WR, 32'h0000_0200 | (32'(s) << CTRL_FS_LSB));
         chk({30'h0, functional_state}, 32'(s));
         rchk(CODE_CTRL_RD, 32'h200 | (32'(s) << 6));
      end
      $display("state codes done");
      wr(CODE_CTRL_WR, 32'h0000_0200);
      wr(CODE_CTRL_WR, 32'h0000_0280);
      n = 0;
      while (sof_run !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(32'(n), 32'(SOFD));
      wr(CODE_CTRL_WR, 32'h0000_0280);
      chk({31'h0, sof_run}, 32'h1);
      port_resume_detect = 1'b1;
      cyc(3);
      chk({30'h0, functional_state}, 32'(FS_OPER));
      wr(CODE_CTRL_WR, 32'h0000_02c0);
      cyc(2);
      chk({30'h0, functional_state}, 32'(FS_RESUME));
      chk({31'h0, sof_run}, 32'h0);
      port_resume_detect = 1'b0;
      $display("state moves done");
      wr(CODE_CTRL_WR, 32'h0000_0600);
      resume_seen_flag = 1'b1;
      cyc(2);
      chk({31'h0, wakeup_signal}, 32'h1);
      rchk(CODE_CTRL_RD, 32'h0000_0600);
      wr(CODE_CTRL_WR, 32'h0000_0200);
      cyc(2);
      chk({31'h0, wakeup_signal}, 32'h0);
      resume_seen_flag = 1'b0;
      wr(CODE_CTRL_WR, 32'h0000_0600);
      $display("wake-up done");
      eof_pulse = 1'b1;
      cyc(1);
      eof_pulse = 1'b0;
      chk({31'h0, overrun_flag_set}, 32'h0);
      periodic_done = 1'b0;
      for (int i = 0; i < 5; i++) begin
         eof_pulse = 1'b1;
         cyc(1);
         eof_pulse = 1'b0;
         chk({31'h0, overrun_flag_set}, 32'h1);
         cyc(1);
         chk({31'h0, overrun_flag_set}, 32'h0);
      end
      ce = 1'b0;
      eof_pulse = 1'b1;
      cyc(1);
      {ce, eof_pulse} = 2'b10;
      rchk(CODE_CMD_RD, 32'h0001_0000);
      wr(CODE_CMD_WR, 32'h0000_0000);
      rchk(CODE_CMD_RD, 32'h0001_0000);
      rchk(CODE_CMD_RD, 32'h0001_0000);
      rchk(CODE_CTRL_RD, 32'h0000_0600);
      $display("overrun count done");
      wr(8'h83, 32'hffff_ffff);
      rchk(8'h03, 32'h0000_0000);
      rchk(CODE_CMD_RD, 32'h0001_0000);
      ce = 1'b0;
      wr(CODE_CTRL_WR, 32'h0000_0200);
      ce = 1'b1;
      rchk(CODE_CTRL_RD, 32'h0000_0600);
      wr(CODE_CMD_WR, 32'h0000_0001);
      cyc(4);
      chk({31'h0, hub_reset}, 32'h0);
      rchk(CODE_CTRL_RD, 32'h0000_0600);
      rchk(CODE_CMD_RD, 32'h0001_0000);
      hw_reset();
      rchk(CODE_CTRL_RD, 32'h0000_0000);
      $display("resets done");
      end_of_test();
   end
endmodule
